/* common/bpcm_defs.vh */
// constants for the panel batch control menu block
`ifndef BPCM_DEFS_VH
`define BPCM_DEFS_VH
`define BPCM_CODE_DEFAULT   16'h0000
`define BPCM_DELAY_DEFAULT  16'h0000
`define BPCM_STOP_DEFAULT   32'h00000000
`define BPCM_SUB_LAST       2'h3
`define BPCM_SUB_INFO       2'h3
`define BPCM_SUB_SYSTEM     2'h0
`define BPCM_CTRL_BOTH      2'h2
`define BPCM_CTRL_LOCAL     2'h0
`define BPCM_CTRL_REMOTE    2'h1
`define BPCM_OPT_LAST       3'h7
`define BPCM_DIGIT_LAST     2'h3
`define BPCM_DIGIT_MAX      4'h9
`define BPCM_BLINK_HALF     24'h7A11FF
`define BPCM_COUNT_UP       1'b0
`endif

/* hdl/bpcm_menu.v */
// operator key mapping, access gating and menu navigation for the batch panel
//
// What this block does
// - remote switches mean start/stop/reset/menu running, down/up/program/enter configuring.
// - inhibit link during batch freezes outputs and stops adding counts.
// - configuration menus open only while security link is closed.
// - with supply removed every switch output is open.
// - from Ready, program plus enter together, or operator menu route, enters configuration.
// - configuration entry refused while a batch runs.
// - highlight steady on menus, blinking on options and variables.
// - functions depending on an unselected option are hidden.
// - main menu has exactly four sub-menus, last one read-only information.
// - two separate four digit codes, configuration and operator, default zero.
// - default user controls accept both front panel and remote keys.
// - second and third control delay and stop point default to zero.
// - counter defaults to counting up, overrun compensation off.
// - an all zero configuration code disables the code check on configuration entry; the operator code is stored but never checked.
`timescale 1ns/10ps
`default_nettype none
`include "bpcm_defs.vh"
module bpcm_menu (
    input  wire        i_clk,
    input  wire        i_rst,
    input  wire        i_power_good,
    input  wire        i_key_down,
    input  wire        i_key_up,
    input  wire        i_key_prog,
    input  wire        i_key_enter,
    input  wire        i_remote_switch_one,
    input  wire        i_remote_switch_two,
    input  wire        i_remote_switch_three,
    input  wire        i_remote_switch_four,
    input  wire        i_inhibit_link,
    input  wire        i_security_link,
    input  wire        i_ready,
    input  wire        i_running,
    input  wire        i_op_menu_config_en,
    input  wire        i_op_menu_config_req,
    input  wire [15:0] i_code_entered,
    input  wire        i_pulse_input_sel,
    input  wire        i_item_dependent,
    input  wire        i_item_is_option,
    input  wire        i_count_pulse,
    input  wire [2:0]  i_out_request,
    output wire        o_start,
    output wire        o_stop,
    output wire        o_reset,
    output wire        o_menu,
    output reg         o_count_add,
    output reg  [2:0]  o_switch_out,
    output reg  [4:0]  o_menu_state,
    output reg  [1:0]  o_sub_sel,
    output reg  [2:0]  o_item_sel,
    output reg  [2:0]  o_opt_sel,
    output reg  [1:0]  o_digit_sel,
    output reg  [15:0] o_value,
    output reg         o_highlight_on,
    output reg         o_item_hidden,
    output reg         o_config_refused,
    output reg         o_store_option,
    output reg         o_store_value,
    output reg  [15:0] o_config_code,
    output reg  [15:0] o_operator_code,
    output reg  [1:0]  o_user_controls,
    output reg  [15:0] o_second_control_delay,
    output reg  [31:0] o_second_control_stop_point,
    output reg  [15:0] o_third_control_delay,
    output reg  [31:0] o_third_control_stop_point,
    output reg         o_count_down,
    output reg         o_overrun_comp
);

localparam ST_OPER = 5'h01;
localparam ST_MAIN = 5'h02;
localparam ST_SUB  = 5'h04;
localparam ST_OPT  = 5'h08;
localparam ST_NUM  = 5'h10;

// digit step with wrap, used for both directions
function [3:0] bpcm_digit_step;
    input [3:0] d;
    input       up;
    begin
        if (up)
            bpcm_digit_step = (d == `BPCM_DIGIT_MAX) ? 4'h0 : d + 4'h1;
        else
            bpcm_digit_step = (d == 4'h0) ? `BPCM_DIGIT_MAX : d - 4'h1;
    end
endfunction

// option items that land in a setting all live in the system sub-menu
function bpcm_sys_item;
    input [1:0] sub;
    input [2:0] item;
    input [2:0] want;
    begin
        bpcm_sys_item = (sub == `BPCM_SUB_SYSTEM) && (item == want);
    end
endfunction

reg         local_en;
reg         remote_en;
reg         k_down;
reg         k_up;
reg         k_prog;
reg         k_enter;
reg  [3:0]  keys_ff;
reg  [3:0]  nxt_keys;
wire [3:0]  key_rise;
reg  [23:0] blink_cnt_ff;
reg         blink_ff;
reg  [3:0]  cur_digit;
reg  [3:0]  new_digit;
wire        cfg_code_ok;
wire        entry_req;
wire        entry_ok;
wire        running_state;

always @* begin
    local_en  = (o_user_controls != `BPCM_CTRL_REMOTE);
    remote_en = (o_user_controls != `BPCM_CTRL_LOCAL);
    // same remote contacts become navigation keys in configuration
    k_down  = (local_en & i_key_down)  | (remote_en & i_remote_switch_one);
    k_up    = (local_en & i_key_up)    | (remote_en & i_remote_switch_two);
    k_prog  = (local_en & i_key_prog)  | (remote_en & i_remote_switch_three);
    k_enter = (local_en & i_key_enter) | (remote_en & i_remote_switch_four);
    nxt_keys = {k_enter, k_prog, k_up, k_down};
end

assign key_rise = nxt_keys & ~keys_ff;
assign running_state = (o_menu_state == ST_OPER);
assign o_start = running_state & k_down;
assign o_stop  = running_state & k_up;
assign o_reset = running_state & k_prog;
assign o_menu  = running_state & k_enter;

// zero code means no code check at all
assign cfg_code_ok = (o_config_code == `BPCM_CODE_DEFAULT) | (i_code_entered == o_config_code);
// both keys held together; the second key's edge starts it
assign entry_req = (k_prog & k_enter & (key_rise[2] | key_rise[3]))
                 | (i_op_menu_config_en & i_op_menu_config_req);
assign entry_ok = i_ready & ~i_running & i_security_link & cfg_code_ok;

// keys start from released, so a key held through reset gives a rising edge on the first clock after reset
// blink runs free; its phase on entry is not aligned to the key press
always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        keys_ff      <= 4'h0;
        blink_cnt_ff <= 24'h000000;
        blink_ff     <= 1'b0;
    end else begin
        keys_ff <= nxt_keys;
        if (blink_cnt_ff == `BPCM_BLINK_HALF) begin
            blink_cnt_ff <= 24'h000000;
            blink_ff     <= ~blink_ff;
        end else begin
            blink_cnt_ff <= blink_cnt_ff + 24'h000001;
        end
    end
end

always @* begin
    case (o_digit_sel)
        2'h0:    cur_digit = o_value[3:0];
        2'h1:    cur_digit = o_value[7:4];
        2'h2:    cur_digit = o_value[11:8];
        default: cur_digit = o_value[15:12];
    endcase
    new_digit = bpcm_digit_step(cur_digit, key_rise[1]);
end

always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        o_count_add  <= 1'b0;
        o_switch_out <= 3'h0;
    end else begin
        // outputs hold but the flow keeps going, only the count is lost
        o_count_add <= i_count_pulse & ~(i_running & i_inhibit_link);
        if (!i_power_good)
            o_switch_out <= 3'h0;
        else if (!(i_running & i_inhibit_link))
            o_switch_out <= i_out_request;
    end
end

always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        o_menu_state     <= ST_OPER;
        o_sub_sel        <= `BPCM_SUB_SYSTEM;
        o_item_sel       <= 3'h0;
        o_opt_sel        <= 3'h0;
        o_digit_sel      <= 2'h0;
        o_value          <= 16'h0000;
        o_highlight_on   <= 1'b0;
        o_item_hidden    <= 1'b0;
        o_config_refused <= 1'b0;
        o_store_option   <= 1'b0;
        o_store_value    <= 1'b0;
        o_config_code    <= `BPCM_CODE_DEFAULT;
        o_operator_code  <= `BPCM_CODE_DEFAULT;
        o_user_controls  <= `BPCM_CTRL_BOTH;
        o_second_control_delay      <= `BPCM_DELAY_DEFAULT;
        o_second_control_stop_point <= `BPCM_STOP_DEFAULT;
        o_third_control_delay       <= `BPCM_DELAY_DEFAULT;
        o_third_control_stop_point  <= `BPCM_STOP_DEFAULT;
        o_count_down     <= `BPCM_COUNT_UP;
        o_overrun_comp   <= 1'b0;
    end else begin
        o_store_option   <= 1'b0;
        o_store_value    <= 1'b0;
        o_config_refused <= 1'b0;
        // calibration items hide under a pulse input
        o_item_hidden  <= i_item_dependent & i_pulse_input_sel;
        // steady on menus, blinking on options and digits
        o_highlight_on <= (o_menu_state == ST_OPT || o_menu_state == ST_NUM) ? blink_ff
                        : (o_menu_state != ST_OPER);
        case (o_menu_state)
            ST_OPER: begin
                if (entry_req) begin
                    if (entry_ok) begin
                        o_menu_state <= ST_MAIN;
                        o_sub_sel    <= `BPCM_SUB_SYSTEM;
                    end else begin
                        o_config_refused <= 1'b1;
                    end
                end
            end
            ST_MAIN: begin
                // four entries only, wrapping is avoided so the ends are clear
                if (key_rise[1] && o_sub_sel != `BPCM_SUB_LAST)
                    o_sub_sel <= o_sub_sel + 2'h1;
                else if (key_rise[0] && o_sub_sel != `BPCM_SUB_SYSTEM)
                    o_sub_sel <= o_sub_sel - 2'h1;
                else if (key_rise[2]) begin
                    o_menu_state <= ST_SUB;
                    o_item_sel   <= 3'h0;
                end else if (key_rise[3])
                    o_menu_state <= ST_OPER;
            end
            ST_SUB: begin
                if (key_rise[1])
                    o_item_sel <= o_item_sel + 3'h1;
                else if (key_rise[0])
                    o_item_sel <= o_item_sel - 3'h1;
                else if (key_rise[2] && !o_item_hidden && o_sub_sel != `BPCM_SUB_INFO) begin
                    o_menu_state <= i_item_is_option ? ST_OPT : ST_NUM;
                    o_opt_sel    <= 3'h0;
                    o_digit_sel  <= 2'h0;
                    o_value      <= 16'h0000;
                end else if (key_rise[3])
                    o_menu_state <= ST_MAIN;
            end
            ST_OPT: begin
                if (key_rise[1] && o_opt_sel != `BPCM_OPT_LAST)
                    o_opt_sel <= o_opt_sel + 3'h1;
                else if (key_rise[0] && o_opt_sel != 3'h0)
                    o_opt_sel <= o_opt_sel - 3'h1;
                else if (key_rise[3]) begin
                    o_store_option <= 1'b1;
                    o_menu_state   <= ST_SUB;
                    // a remote-only choice locks out the front keys at once
                    if (bpcm_sys_item(o_sub_sel, o_item_sel, 3'h0))
                        o_user_controls <= o_opt_sel[1:0];
                    if (bpcm_sys_item(o_sub_sel, o_item_sel, 3'h1))
                        o_count_down <= o_opt_sel[0];
                    if (bpcm_sys_item(o_sub_sel, o_item_sel, 3'h2))
                        o_overrun_comp <= o_opt_sel[0];
                end
            end
            ST_NUM: begin
                if (key_rise[1] || key_rise[0]) begin
                    case (o_digit_sel)
                        2'h0:    o_value[3:0]   <= new_digit;
                        2'h1:    o_value[7:4]   <= new_digit;
                        2'h2:    o_value[11:8]  <= new_digit;
                        default: o_value[15:12] <= new_digit;
                    endcase
                end else if (key_rise[2] && o_digit_sel != `BPCM_DIGIT_LAST)
                    o_digit_sel <= o_digit_sel + 2'h1;
                else if (key_rise[3]) begin
                    o_store_value <= 1'b1;
                    o_menu_state  <= ST_SUB;
                    case (o_item_sel)
                        3'h0:    o_config_code          <= o_value;
                        3'h1:    o_operator_code        <= o_value;
                        3'h2:    o_second_control_delay <= o_value;
                        3'h3:    o_third_control_delay  <= o_value;
                        3'h4:    o_second_control_stop_point <= {16'h0000, o_value};
                        3'h5:    o_third_control_stop_point  <= {16'h0000, o_value};
                        default: o_menu_state <= ST_SUB;
                    endcase
                end
            end
            default: o_menu_state <= ST_OPER;
        endcase
    end
end

endmodule // bpcm_menu
`default_nettype wire

/* tb/bpcm_menu_properties.sv */
// concurrent checks on the menu block ports
`timescale 1ns/10ps
`default_nettype none
module bpcm_menu_properties (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_power_good,
    input wire logic       i_running,
    input wire logic       i_inhibit_link,
    input wire logic       i_security_link,
    input wire logic       i_count_pulse,
    input wire logic       i_key_down,
    input wire logic       i_key_up,
    input wire logic       i_key_prog,
    input wire logic       i_key_enter,
    input wire logic       i_remote_switch_one,
    input wire logic       i_remote_switch_two,
    input wire logic       o_start,
    input wire logic       o_stop,
    input wire logic       o_count_add,
    input wire logic [2:0] o_switch_out,
    input wire logic [4:0] o_menu_state,
    input wire logic       o_config_refused,
    input wire logic       o_store_value
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_oper;
        o_menu_state == 5'h01;
    endsequence
    sequence s_count;
        i_count_pulse && !(i_running && i_inhibit_link);
    endsequence
    wire front_idle = !(i_key_down | i_key_up | i_key_prog | i_key_enter);
    chk_power_open: assert property (!i_power_good |=> o_switch_out == 3'h0)
        else $error("switch outputs not open after supply loss");
    chk_inhibit_hold: assert property (i_power_good && i_running && i_inhibit_link |=> $stable(o_switch_out))
        else $error("switch outputs moved under inhibit");
    chk_inhibit_count: assert property (i_running && i_inhibit_link |=> !o_count_add)
        else $error("count added under inhibit");
    chk_count_pass: assert property (s_count |=> o_count_add)
        else $error("count pulse lost");
    chk_remote_map: assert property (s_oper ##0 front_idle |-> o_start == i_remote_switch_one && o_stop == i_remote_switch_two)
        else $error("remote run functions wrong");
    chk_run_no_entry: assert property (s_oper ##0 i_running |=> s_oper)
        else $error("menu entered while running");
    chk_link_gate: assert property (s_oper ##0 !i_security_link |=> s_oper)
        else $error("menu entered with link open");
    chk_refuse_stay: assert property (o_config_refused |-> s_oper)
        else $error("refusal left operation state");
    chk_store_back: assert property (o_store_value |-> o_menu_state == 5'h04)
        else $error("value store did not return to sub-menu");
endmodule // bpcm_menu_properties
bind bpcm_menu bpcm_menu_properties bpcm_menu_properties_inst (.*);
`default_nettype wire

/* tb/bpcm_panel_model.sv */
// pushbutton and remote contact model
`timescale 1ns/10ps
`default_nettype none
module bpcm_panel_model (
    input  wire logic       i_remote,
    input  wire logic [3:0] i_press,
    output logic            o_key_down,
    output logic            o_key_up,
    output logic            o_key_prog,
    output logic            o_key_enter,
    output logic [3:0]      o_remote
);
    // open contacts read low, pull-down on the device side
    assign o_key_down  = i_press[3] & ~i_remote;
    assign o_key_up    = i_press[2] & ~i_remote;
    assign o_key_prog  = i_press[1] & ~i_remote;
    assign o_key_enter = i_press[0] & ~i_remote;
    assign o_remote    = i_remote ? i_press : 4'h0;
endmodule // bpcm_panel_model
`default_nettype wire

/* tb/bpcm_menu_tb_top.sv */
// self-checking bench for the menu block
`timescale 1ns/10ps
`default_nettype none
module bpcm_menu_tb_top;
    logic clk = 1'b0, rst, pwr, inh, sec, rdy, run, op_en, op_req, psel, idep, iopt, cnt, rem;
    logic [3:0] press;
    logic [15:0] code;
    logic [2:0] oreq;
    wire kd, ku, kp, ke, st, sp, rs, mn, cadd, hl, hid, cdn, ovr;
    wire [3:0] rsw;
    wire [2:0] swo;
    wire [4:0] mst;
    wire [1:0] sub, uctl;
    wire [15:0] ccode, ocode, d2, d3;
    wire [31:0] s2, s3;
    int mismatches = 0, total_checks = 0;
    always #10 clk = ~clk;
    bpcm_panel_model bpcm_panel_model_inst (.i_remote(rem), .i_press(press), .o_key_down(kd), .o_key_up(ku),
        .o_key_prog(kp), .o_key_enter(ke), .o_remote(rsw));
    bpcm_menu bpcm_menu_inst (.i_clk(clk), .i_rst(rst), .i_power_good(pwr), .i_key_down(kd), .i_key_up(ku),
        .i_key_prog(kp), .i_key_enter(ke), .i_remote_switch_one(rsw[3]), .i_remote_switch_two(rsw[2]),
        .i_remote_switch_three(rsw[1]), .i_remote_switch_four(rsw[0]), .i_inhibit_link(inh),
        .i_security_link(sec), .i_ready(rdy), .i_running(run), .i_op_menu_config_en(op_en),
        .i_op_menu_config_req(op_req), .i_code_entered(code), .i_pulse_input_sel(psel),
        .i_item_dependent(idep), .i_item_is_option(iopt), .i_count_pulse(cnt), .i_out_request(oreq),
        .o_start(st), .o_stop(sp), .o_reset(rs), .o_menu(mn), .o_count_add(cadd), .o_switch_out(swo),
        .o_menu_state(mst), .o_sub_sel(sub), .o_item_sel(), .o_opt_sel(), .o_digit_sel(), .o_value(),
        .o_highlight_on(hl), .o_item_hidden(hid), .o_config_refused(), .o_store_option(), .o_store_value(),
        .o_config_code(ccode), .o_operator_code(ocode), .o_user_controls(uctl),
        .o_second_control_delay(d2), .o_second_control_stop_point(s2), .o_third_control_delay(d3),
        .o_third_control_stop_point(s3), .o_count_down(cdn), .o_overrun_comp(ovr));
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    // held three cycles, keys act once per rising edge
    task automatic key(input logic [3:0] m);
        @(posedge clk) press <= m;
        repeat (3) @(posedge clk);
        press <= 4'h0;
        wt(3);
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic print_verdict;
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
    initial begin
        {pwr, inh, sec, rdy, run, op_en, op_req, psel, idep, iopt, cnt, rem} = 12'h800;
        press = 4'h0; code = 16'h0000; oreq = 3'h0; rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        wt(1);
        chk("state", 5'h01, mst);
        chk("controls", 2'h2, uctl);
        chk("codes", 32'h0, {ccode, ocode});
        chk("delays", 32'h0, {d2, d3});
        chk("stop2", 32'h0, s2);
        chk("stop3", 32'h0, s3);
        chk("direction", 2'h0, {cdn, ovr});
        @(posedge clk) begin run <= 1'b1; rem <= 1'b1; end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) press <= 4'h8 >> i;
            wt(1);
            chk("remote", 4'h8 >> i, {st, sp, rs, mn});
            @(posedge clk) press <= 4'h0;
        end
        @(posedge clk) begin rem <= 1'b0; sec <= 1'b1; end
        key(4'h3);
        chk("running", 5'h01, mst);
        @(posedge clk) begin inh <= 1'b1; oreq <= 3'h5; cnt <= 1'b1; end
        wt(2);
        chk("inh_out", 3'h0, swo);
        chk("inh_cnt", 1'b0, cadd);
        @(posedge clk) inh <= 1'b0;
        wt(2);
        chk("out", 3'h5, swo);
        chk("cnt", 1'b1, cadd);
        @(posedge clk) begin pwr <= 1'b0; cnt <= 1'b0; end
        wt(1);
        chk("power", 3'h0, swo);
        @(posedge clk) begin pwr <= 1'b1; run <= 1'b0; rdy <= 1'b1; sec <= 1'b0; end
        key(4'h3);
        chk("link", 5'h01, mst);
        @(posedge clk) sec <= 1'b1;
        key(4'h3);
        chk("entry", 5'h02, mst);
        chk("steady", 1'b1, hl);
        repeat (4) key(4'h4);
        chk("sub_top", 2'h3, sub);
        key(4'h2);
        chk("info_open", 5'h04, mst);
        key(4'h2);
        chk("info", 5'h04, mst);
        key(4'h1);
        chk("info_back", 5'h02, mst);
        repeat (3) key(4'h8);
        chk("sub_low", 2'h0, sub);
        key(4'h2);
        chk("open", 5'h04, mst);
        key(4'h2);
        chk("numeric", 5'h10, mst);
        @(posedge clk) rem <= 1'b1;
        key(4'h4);
        key(4'h2);
        key(4'h4);
        key(4'h4);
        key(4'h1);
        chk("stored", 5'h04, mst);
        chk("code", 16'h0021, ccode);
        @(posedge clk) begin rem <= 1'b0; idep <= 1'b1; psel <= 1'b1; end
        wt(2);
        chk("hidden", 1'b1, hid);
        @(posedge clk) psel <= 1'b0;
        wt(2);
        chk("shown", 1'b0, hid);
        @(posedge clk) iopt <= 1'b1;
        key(4'h2);
        chk("option", 5'h08, mst);
        key(4'h4);
        key(4'h4);
        key(4'h1);
        chk("opt_back", 5'h04, mst);
        chk("opt_store", 2'h2, uctl);
        key(4'h1);
        key(4'h1);
        chk("oper", 5'h01, mst);
        key(4'h3);
        chk("bad_code", 5'h01, mst);
        @(posedge clk) code <= 16'h0021;
        key(4'h3);
        chk("good_code", 5'h02, mst);
        key(4'h1);
        @(posedge clk) begin op_en <= 1'b1; op_req <= 1'b1; end
        wt(2);
        chk("op_route", 5'h02, mst);
        print_verdict();
    end
endmodule // bpcm_menu_tb_top
`default_nettype wire
